// >>> rtl/psc_burst_sram.sv
// Pipelined synchronous burst memory, 32K words of 36 bits, with controls
//
// Summary of operation
// - Array holds 32K words of 36 bits in four byte lanes.
// - Address, data and controls are registered on the rising clock edge.
// - Controller strobe starts a read, write or deselect cycle.
// - Processor strobe starts a read or deselect cycle, never a write.
// - Processor strobe with primary enable high never deselects.
// - A 2-bit counter on the low address bits makes burst addresses.
// - Sampled advance steps the counter in the selected order.
// - Order select low gives linear order, high gives interleaved.
// - Writes are self-timed from the clock edge, no write pulse.
// - Each lane write strobe governs exactly one byte lane a to d.
// - Without global write, only lanes with strobe and qualifier both asserted are written.
// - Global write, or all strobes with qualifier, writes all lanes.
// - Read data sits in an output register, released next edge.
// - Data pins are driven while output enable was low three edges earlier.
// - A write is any strobe with qualifier low, or global write low.
// - Primary enable is active low; high blocks the processor strobe.
// - Selected only with second enable high and third enable low.
`timescale 1ns/100ps
module psc_burst_sram (
	input  wire logic                       clk_sys_i,
	input  wire logic                       rst_n_i,
	input  wire logic [psc_pkg::ADDR_W-1:0] address_in_i,
	input  wire logic                       controller_addr_strobe_n_i,
	input  wire logic                       processor_addr_strobe_n_i,
	input  wire logic                       burst_advance_n_i,
	input  wire logic [psc_pkg::LANES-1:0]  lane_write_strobe_n_i,
	input  wire logic                       global_write_n_i,
	input  wire logic                       write_qualifier_n_i,
	input  wire logic                       chip_enable_primary_n_i,
	input  wire logic                       chip_enable_second_i,
	input  wire logic                       chip_enable_third_n_i,
	input  wire logic                       burst_order_select_i,
	input  wire logic                       output_enable_n_i,
	input  wire logic [psc_pkg::DATA_W-1:0] byte_lane_data_i,
	output logic      [psc_pkg::DATA_W-1:0] byte_lane_data_o,
	output logic      [psc_pkg::DATA_W-1:0] byte_lane_data_oe_o
);

	psc_pkg::psc_pins_t                 pins_ff;
	psc_pkg::psc_state_t                state_ff;
	psc_pkg::psc_state_t                nxt_state;
	logic [psc_pkg::HI_W-1:0]           addr_hi_ff;
	logic [psc_pkg::HI_W-1:0]           nxt_addr_hi;
	logic [psc_pkg::LOW_W-1:0]          base_low_ff;
	logic [psc_pkg::LOW_W-1:0]          nxt_base_low;
	logic [psc_pkg::LOW_W-1:0]          cnt_ff;
	logic [psc_pkg::LOW_W-1:0]          nxt_cnt;
	logic [psc_pkg::DATA_W-1:0]         rd_ff;
	logic                               oe_meta_ff;
	logic                               oe_sync_ff;
	logic                               order_meta_ff;
	logic                               order_sync_ff;
	logic                               ce_ok;
	logic                               proc_start;
	logic                               ctrl_start;
	logic                               op_en;
	logic                               op_write;
	logic [psc_pkg::LANES-1:0]          lane_we;
	logic [psc_pkg::LANES-1:0]          wr_lanes;
	logic [psc_pkg::ADDR_W-1:0]         op_addr;
	wire logic [psc_pkg::DATA_W-1:0]    rd_word;

	// Low address of a burst step; both orders wrap within four words
	function automatic logic [psc_pkg::LOW_W-1:0] burst_low(
		input logic [psc_pkg::LOW_W-1:0] base,
		input logic [psc_pkg::LOW_W-1:0] cnt,
		input logic                      interleave
	);
		burst_low = interleave ? (base ^ cnt) : (base + cnt);
	endfunction : burst_low

	// Every pin the controller drives is registered before use
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pins_ff <= psc_pkg::PINS_RST;
		end else begin
			pins_ff.addr_hi        <= address_in_i[psc_pkg::ADDR_W-1:
				psc_pkg::LOW_W];
			pins_ff.addr_low_pair  <= address_in_i[psc_pkg::LOW_W-1:0];
			pins_ff.data           <= byte_lane_data_i;
			pins_ff.ctrl_strobe_n  <= controller_addr_strobe_n_i;
			pins_ff.proc_strobe_n  <= processor_addr_strobe_n_i;
			pins_ff.advance_n      <= burst_advance_n_i;
			pins_ff.lane_strobe_n  <= lane_write_strobe_n_i;
			pins_ff.global_write_n <= global_write_n_i;
			pins_ff.write_qual_n   <= write_qualifier_n_i;
			pins_ff.ce_primary_n   <= chip_enable_primary_n_i;
			pins_ff.ce_second      <= chip_enable_second_i;
			pins_ff.ce_third_n     <= chip_enable_third_n_i;
		end
	end

	// Order select and output enable are unclocked pins, so synchronise
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			oe_meta_ff    <= 1'b1;
			oe_sync_ff    <= 1'b1;
			order_meta_ff <= 1'b0;
			order_sync_ff <= 1'b0;
		end else begin
			oe_meta_ff    <= output_enable_n_i;
			oe_sync_ff    <= oe_meta_ff;
			order_meta_ff <= burst_order_select_i;
			order_sync_ff <= order_meta_ff;
		end
	end

	always_comb begin
		ce_ok = !pins_ff.ce_primary_n && pins_ff.ce_second
			&& !pins_ff.ce_third_n;
		// Primary enable high masks the processor strobe entirely
		proc_start = !pins_ff.proc_strobe_n
			&& !pins_ff.ce_primary_n;
		ctrl_start = !pins_ff.ctrl_strobe_n && !proc_start;
		if (!pins_ff.global_write_n) begin
			wr_lanes = psc_pkg::LANES_ALL;
		end else if (!pins_ff.write_qual_n) begin
			wr_lanes = ~pins_ff.lane_strobe_n;
		end else begin
			wr_lanes = psc_pkg::LANES_OFF;
		end
		op_write = |wr_lanes;
	end

	always_comb begin
		nxt_state    = state_ff;
		nxt_addr_hi  = addr_hi_ff;
		nxt_base_low = base_low_ff;
		nxt_cnt      = cnt_ff;
		op_en        = 1'b0;
		lane_we      = psc_pkg::LANES_OFF;
		op_addr      = {addr_hi_ff,
			burst_low(base_low_ff, cnt_ff, order_sync_ff)};
		if (proc_start || ctrl_start) begin
			nxt_state = ce_ok ? psc_pkg::ST_BURST : psc_pkg::ST_DESEL;
			if (ce_ok) begin
				nxt_addr_hi  = pins_ff.addr_hi;
				nxt_base_low = pins_ff.addr_low_pair;
				nxt_cnt      = psc_pkg::CNT_RST;
				op_en        = 1'b1;
				op_addr      = {pins_ff.addr_hi, pins_ff.addr_low_pair};
				// A processor-strobe start is always a read
				lane_we      = ctrl_start ? wr_lanes : psc_pkg::LANES_OFF;
			end
		end else begin
			case (state_ff)
				psc_pkg::ST_BURST: begin
					op_en   = 1'b1;
					lane_we = wr_lanes;
					if (!pins_ff.advance_n) begin
						nxt_cnt = cnt_ff + psc_pkg::CNT_STEP;
						op_addr = {addr_hi_ff, burst_low(base_low_ff,
							nxt_cnt, order_sync_ff)};
					end
					// Advance idle: address stays put
				end
				psc_pkg::ST_DESEL: begin
					op_en = 1'b0;
				end
				default: begin
					nxt_state = psc_pkg::ST_DESEL;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff    <= psc_pkg::ST_DESEL;
			addr_hi_ff  <= psc_pkg::HI_RST;
			base_low_ff <= psc_pkg::CNT_RST;
			cnt_ff      <= psc_pkg::CNT_RST;
		end else begin
			state_ff    <= nxt_state;
			addr_hi_ff  <= nxt_addr_hi;
			base_low_ff <= nxt_base_low;
			cnt_ff      <= nxt_cnt;
		end
	end

	// Each lane owns its array, so no two processes write one variable
	for (genvar l = 0; l < psc_pkg::LANES; l++) begin : g_lane
		logic [psc_pkg::LANE_W-1:0] lane_mem [psc_pkg::WORDS];

		// Written on the edge itself, so no pulse shaping is needed
		always_ff @(posedge clk_sys_i) begin
			if (op_en && lane_we[l]) begin
				lane_mem[op_addr] <=
					pins_ff.data[l*psc_pkg::LANE_W +: psc_pkg::LANE_W];
			end
		end

		assign rd_word[l*psc_pkg::LANE_W +: psc_pkg::LANE_W] =
			lane_mem[op_addr];
	end

	// Array word lands in rd_ff, then the output register next edge
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_ff            <= psc_pkg::DATA_RST;
			byte_lane_data_o <= psc_pkg::DATA_RST;
		end else begin
			// Write pins on a processor-strobe start must not block the read
			if (op_en && !(op_write && !proc_start)) begin
				rd_ff <= rd_word;
			end
			byte_lane_data_o <= rd_ff;
		end
	end

	// Enable follows the pin three edges late; bus turnaround needs margin
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			byte_lane_data_oe_o <= '0;
		end else begin
			byte_lane_data_oe_o <= {psc_pkg::DATA_W{!oe_sync_ff}};
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	chk_ctrl_begin: assert property (
		ctrl_start && ce_ok |=> state_ff == psc_pkg::ST_BURST
			&& cnt_ff == psc_pkg::CNT_RST
			&& addr_hi_ff == $past(pins_ff.addr_hi))
		else $error("controller strobe did not begin a cycle");

	chk_proc_read: assert property (
		proc_start && ce_ok |-> lane_we == psc_pkg::LANES_OFF
			##1 state_ff == psc_pkg::ST_BURST)
		else $error("processor strobe start was not a read");

	chk_proc_blocked: assert property (
		!pins_ff.proc_strobe_n && pins_ff.ce_primary_n
			&& pins_ff.ctrl_strobe_n |=> $stable(state_ff))
		else $error("blocked processor strobe changed the state");

	chk_depth_select: assert property (
		(proc_start || ctrl_start) && (!pins_ff.ce_second
			|| pins_ff.ce_third_n) |=> state_ff == psc_pkg::ST_DESEL)
		else $error("depth enables did not deselect");

	chk_burst_step: assert property (
		state_ff == psc_pkg::ST_BURST && !proc_start && !ctrl_start
			&& !pins_ff.advance_n |=> cnt_ff == $past(cnt_ff) + 2'h1)
		else $error("advance did not step the counter");

	chk_burst_hold: assert property (
		!proc_start && !ctrl_start && pins_ff.advance_n
			|=> $stable(cnt_ff) && $stable(base_low_ff))
		else $error("burst address moved without advance");

	chk_burst_order: assert property (
		state_ff == psc_pkg::ST_BURST && !proc_start && !ctrl_start
			&& pins_ff.advance_n |-> op_addr[1:0] == (order_sync_ff
			? base_low_ff ^ cnt_ff : base_low_ff + cnt_ff))
		else $error("burst low address in wrong order");

	chk_global_write: assert property (
		!pins_ff.global_write_n |-> wr_lanes == psc_pkg::LANES_ALL)
		else $error("global write missed a lane");

	chk_lane_write: assert property (
		pins_ff.global_write_n |-> wr_lanes == (pins_ff.write_qual_n
			? psc_pkg::LANES_OFF : ~pins_ff.lane_strobe_n))
		else $error("lane write enables wrong");

	chk_out_register: assert property (
		op_en && !(op_write && !proc_start)
			|=> ##1 byte_lane_data_o == $past(rd_word, 2))
		else $error("read data not released from output register");

	chk_out_enable: assert property (
		output_enable_n_i [*3] |=> byte_lane_data_oe_o == '0)
		else $error("data pins driven with output enable high");

endmodule : psc_burst_sram

// >>> rtl/psc_pkg.sv
// Shared constants and types for the pipelined burst memory control block
package psc_pkg;

	localparam int ADDR_W   = 15;
	localparam int LOW_W    = 2;
	localparam int HI_W     = ADDR_W - LOW_W;
	localparam int LANES    = 4;
	localparam int LANE_W   = 9;
	localparam int DATA_W   = LANES * LANE_W;
	localparam int WORDS    = 32768;

	localparam logic [LOW_W-1:0]  CNT_RST   = 2'h0;
	localparam logic [LOW_W-1:0]  CNT_STEP  = 2'h1;
	localparam logic [LANES-1:0]  LANES_ALL = 4'hF;
	localparam logic [LANES-1:0]  LANES_OFF = 4'h0;
	localparam logic [DATA_W-1:0] DATA_RST  = 36'h0_0000_0000;
	localparam logic [HI_W-1:0]   HI_RST    = 13'h0000;

	// Sampled pin group, all strobes active low except the second enable
	typedef struct packed {
		logic [HI_W-1:0]  addr_hi;
		logic [LOW_W-1:0] addr_low_pair;
		logic [DATA_W-1:0] data;
		logic             ctrl_strobe_n;
		logic             proc_strobe_n;
		logic             advance_n;
		logic [LANES-1:0] lane_strobe_n;
		logic             global_write_n;
		logic             write_qual_n;
		logic             ce_primary_n;
		logic             ce_second;
		logic             ce_third_n;
	} psc_pins_t;

	// All ones leaves every strobe idle and the third enable deselecting
	localparam psc_pins_t PINS_RST = '1;

	typedef enum logic [0:0] {
		ST_DESEL = 1'b0,
		ST_BURST = 1'b1
	} psc_state_t;

endpackage : psc_pkg

// >>> tb/psc_ctrl_model.sv
// Controller-side partner: resolves the shared data lines of the memory
`timescale 1ns/100ps
module psc_ctrl_model (
	input  wire logic                       clk_sys_i,
	input  wire logic [psc_pkg::DATA_W-1:0] dev_data_i,
	input  wire logic [psc_pkg::DATA_W-1:0] dev_oe_i,
	input  wire logic [psc_pkg::DATA_W-1:0] ctrl_data_i,
	input  wire logic                       ctrl_oe_i,
	output logic      [psc_pkg::DATA_W-1:0] wire_o
);
	logic [psc_pkg::DATA_W-1:0] last_ff;

	// Released lines toggle, so a sampled stale value cannot pass as data
	always_comb begin
		for (int i = 0; i < psc_pkg::DATA_W; i++) begin
			wire_o[i] = dev_oe_i[i] ? dev_data_i[i]
				: (ctrl_oe_i ? ctrl_data_i[i] : ~last_ff[i]);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		last_ff <= wire_o;
	end
endmodule : psc_ctrl_model

// >>> tb/test_psc_burst_sram.sv
// Self-checking bench for the pipelined burst memory control block
`timescale 1ns/100ps
module test_psc_burst_sram;
	localparam logic [35:0] D = 36'h1_2345_6780;
	localparam logic [35:0] BW = 36'h0_07FC_01FF;
	logic               clk_sys_i = 1'b0;
	logic               rst_n_i = 1'b0;
	psc_pkg::psc_pins_t pins = psc_pkg::PINS_RST;
	logic               order = 1'b0;
	logic               oe_n = 1'b0;
	logic [35:0]        dout;
	logic [35:0]        doe;
	logic [35:0]        bus;
	logic [2:0]         ev = 3'h0;
	logic [35:0]        ex [3];
	int                 bad_count = 0;
	int                 check_count = 0;
	int                 cycles = 0;

	always #25 clk_sys_i = ~clk_sys_i;

	psc_burst_sram dut_u (
		.clk_sys_i                 (clk_sys_i),
		.rst_n_i                   (rst_n_i),
		.address_in_i              ({pins.addr_hi, pins.addr_low_pair}),
		.controller_addr_strobe_n_i(pins.ctrl_strobe_n),
		.processor_addr_strobe_n_i (pins.proc_strobe_n),
		.burst_advance_n_i         (pins.advance_n),
		.lane_write_strobe_n_i     (pins.lane_strobe_n),
		.global_write_n_i          (pins.global_write_n),
		.write_qualifier_n_i       (pins.write_qual_n),
		.chip_enable_primary_n_i   (pins.ce_primary_n),
		.chip_enable_second_i      (pins.ce_second),
		.chip_enable_third_n_i     (pins.ce_third_n),
		.burst_order_select_i      (order),
		.output_enable_n_i         (oe_n),
		.byte_lane_data_i          (bus),
		.byte_lane_data_o          (dout),
		.byte_lane_data_oe_o       (doe)
	);

	psc_ctrl_model model_u (
		.clk_sys_i  (clk_sys_i),
		.dev_data_i (dout),
		.dev_oe_i   (doe),
		.ctrl_data_i(pins.data),
		.ctrl_oe_i  (~pins.global_write_n | ~pins.write_qual_n),
		.wire_o     (bus)
	);

	task automatic summarize();
		if (bad_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			summarize();
		end
	end

	task automatic chk(string what, logic [35:0] e, logic [35:0] s);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, s);
		end
	endtask : chk

	function automatic psc_pkg::psc_pins_t idle();
		psc_pkg::psc_pins_t p;
		p = psc_pkg::PINS_RST;
		p.ce_primary_n = 1'b0;
		p.ce_third_n = 1'b0;
		return p;
	endfunction : idle

	function automatic psc_pkg::psc_pins_t start(logic [14:0] a);
		psc_pkg::psc_pins_t p;
		p = idle();
		p.ctrl_strobe_n = 1'b0;
		{p.addr_hi, p.addr_low_pair} = a;
		return p;
	endfunction : start

	function automatic psc_pkg::psc_pins_t burst_advance();
		psc_pkg::psc_pins_t p;
		p = idle();
		p.advance_n = 1'b0;
		return p;
	endfunction : burst_advance

	// Read data lands three falling edges after its pins were driven
	task automatic step(psc_pkg::psc_pins_t p, logic v, logic [35:0] e);
		@(negedge clk_sys_i);
		if (ev[2]) chk("read data", ex[2], dout);
		ev = {ev[1:0], v};
		ex[2] = ex[1];
		ex[1] = ex[0];
		ex[0] = e;
		pins = p;
	endtask : step

	task automatic flush();
		repeat (3) step(idle(), 1'b0, 36'h0);
	endtask : flush

	// Output drivers are off around writes to avoid bus contention
	task automatic t_write();
		psc_pkg::psc_pins_t p;
		oe_n = 1'b1;
		flush();
		chk("drive enable off", 36'h0, doe);
		for (int i = 0; i < 4; i++) begin
			p = (i == 0) ? start(15'h0101) : burst_advance();
			if (i[0]) begin
				p.write_qual_n  = 1'b0;
				p.lane_strobe_n = 4'h0;
			end else begin
				p.global_write_n = 1'b0;
			end
			p.data = D + i;
			step(p, 1'b0, 36'h0);
		end
		p = start(15'h0200);
		p.global_write_n = 1'b0;
		p.data = 36'h0;
		step(p, 1'b0, 36'h0);
		p = start(15'h0200);
		p.write_qual_n = 1'b0;
		p.lane_strobe_n = 4'hA;
		p.data = '1;
		step(p, 1'b0, 36'h0);
		p = start(15'h0200);
		p.lane_strobe_n = 4'h0;
		p.data = 36'h0;
		step(p, 1'b0, 36'h0);
		oe_n = 1'b0;
		flush();
		chk("drive enable on", '1, doe);
	endtask : t_write

	task automatic t_read_lin();
		psc_pkg::psc_pins_t p;
		for (int i = 0; i < 4; i++) begin
			p = (i == 0) ? start(15'h0101) : burst_advance();
			step(p, 1'b1, D + i);
		end
		p = start(15'h0200);
		p.ctrl_strobe_n = 1'b1;
		p.proc_strobe_n = 1'b0;
		p.global_write_n = 1'b0;
		step(p, 1'b1, BW);
		p = start(15'h0100);
		p.ctrl_strobe_n = 1'b1;
		p.proc_strobe_n = 1'b0;
		p.ce_primary_n = 1'b1;
		step(p, 1'b1, BW);
		step(start(15'h0101), 1'b1, D);
		step(idle(), 1'b1, D);
		step(burst_advance(), 1'b1, D + 1);
		flush();
	endtask : t_read_lin

	task automatic t_desel();
		psc_pkg::psc_pins_t p;
		p = start(15'h0103);
		p.ce_third_n = 1'b1;
		step(p, 1'b1, D + 1);
		step(burst_advance(), 1'b1, D + 1);
		p = start(15'h0103);
		p.ce_second = 1'b0;
		step(p, 1'b1, D + 1);
		p = start(15'h0103);
		p.ce_primary_n = 1'b1;
		step(p, 1'b1, D + 1);
		step(burst_advance(), 1'b1, D + 1);
		flush();
	endtask : t_desel

	task automatic t_ilv();
		order = 1'b1;
		flush();
		for (int i = 0; i < 4; i++) begin
			step((i == 0) ? start(15'h0101) : burst_advance(), 1'b1,
				D + ((i == 0) ? 0 : 4 - i));
		end
		flush();
		oe_n = 1'b1;
		flush();
		chk("drive enable released", 36'h0, doe);
	endtask : t_ilv

	initial begin
		repeat (8) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rst_n_i = 1'b1;
		t_write();
		t_read_lin();
		t_desel();
		t_ilv();
		summarize();
	end
endmodule : test_psc_burst_sram
